// ==== core/sce_defs.svh ====
`ifndef SCE_DEFS_SVH
`define SCE_DEFS_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define SCE_A_PV_SRC 5'h00
`define SCE_A_SP_SRC 5'h01
`define SCE_A_PRIMARY_OUTPUT_ACT 5'h02
`define SCE_A_SECONDARY_OUTPUT_FN 5'h03
`define SCE_A_PB_A 5'h04
`define SCE_A_PB_B 5'h05
`define SCE_A_TI_A 5'h06
`define SCE_A_TI_B 5'h07
`define SCE_A_IN1_UNIT 5'h08
`define SCE_A_IN2_UNIT 5'h09
`define SCE_A_DP1 5'h0A
`define SCE_A_DP2 5'h0B
`define SCE_A_AL1_FN 5'h0C
`define SCE_A_AL2_FN 5'h0D
`define SCE_A_HOLE 5'h0E
`define SCE_A_STATUS 5'h0F
`define SCE_A_COMM 5'h10
`define SCE_A_LAST 5'h10
`define SCE_NCFG 14

// ----------------------------------------
// Field codes and limits
// ----------------------------------------
`define SCE_PV_FIRST 16'h0000
`define SCE_PV_SECOND 16'h0001
`define SCE_PV_DIFF12 16'h0002
`define SCE_PV_DIFF21 16'h0003
`define SCE_SP_FIRST 16'h0001
`define SCE_SP_SECOND 16'h0002
`define SCE_PRIMARY_OUTPUT_DIRECT 16'h0001
`define SCE_SECONDARY_OUTPUT_COOL 16'h0001
`define SCE_SECONDARY_OUTPUT_ALARM 16'h0002
`define SCE_AL_NONE 16'h0000
`define SCE_AL_TIMER 16'h0001
`define SCE_AL_DIFF_MIN 16'h0004
`define SCE_MAX_PV 16'h0003
`define SCE_MAX_SP 16'h0002
`define SCE_MAX_BIT 16'h0001
`define SCE_MAX_SECONDARY_OUTPUT 16'h0002
`define SCE_MAX_WORD 16'h270F
`define SCE_MAX_UNIT 16'h0002
`define SCE_MAX_DP 16'h0003
`define SCE_MAX_AL 16'h0007

// ----------------------------------------
// Host function codes and error codes
// ----------------------------------------
`define SCE_FN_READ 8'h03
`define SCE_FN_WRITE 8'h06
`define SCE_E_NONE 8'h00
`define SCE_E_PV1 8'h01
`define SCE_E_PV2 8'h02
`define SCE_E_DIFF 8'h03
`define SCE_E_COOL 8'h04
`define SCE_E_UNIT 8'h05
`define SCE_E_AL2 8'h06
`define SCE_E_AL2_SHOWN 8'h08
`define SCE_E_TIMER 8'h07
`define SCE_E_FUNC 8'h0A
`define SCE_E_RANGE 8'h0B
`define SCE_E_NOPAR 8'h0C
`define SCE_E_RDONLY 8'h0E
`define SCE_E_VALUE 8'h0F
`define SCE_E_TUNE 8'h1A

`endif

// ==== core/sce_pkg.sv ====
`include "sce_defs.svh"

package sce_pkg;

    typedef logic [`SCE_NCFG-1:0][15:0] sce_cfg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] func;
        logic [4:0] addr;
        logic [15:0] wdata;
    } sce_req_t;

    typedef struct packed {
        sce_cfg_t cfg;
        logic [7:0] comm_err;
        logic tune_err;
        logic [15:0] rdata;
        logic [7:0] err_code;
        logic [7:0] err_shown;
        logic alarm2;
    } sce_state_t;

endpackage : sce_pkg

// ==== core/sce_checker.sv ====
// What this block does
// - Code 1 when process value and setpoint both use first input.
// - Code 2 when process value and setpoint both use second input.
// - Code 3 when process value is a difference and setpoint an input.
// - Code 4 when output 2 cools and output 1 direct or band/time zero.
// - Code 5 on unit or decimal mismatch while both inputs are combined.
// - Code 6, shown as eight, when output 2 alarms with no alarm 2 function.
// - Output 2 gives no alarm while the alarm 2 function is none.
// - Code 7 when both alarm functions select the dwell timer.
// - Code 10 for an undefined host function code.
// - Code 11 for a host address beyond the implemented range.
// - Code 12 for an in-range address holding no parameter.
// - Code 14 on a write to read-only data; nothing is stored.
// - Code 15 and write rejected when the value is out of range.
// - Code 26 when auto-tuning fails.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`include "sce_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sce_checker
    import sce_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire sce_req_t host_req,
    input wire logic tune_fail,
    input wire logic alarm2_trip,
    output logic [15:0] host_rdata,
    output logic [7:0] err_code,
    output logic [7:0] err_shown,
    output logic alarm2_out
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] max_of(input logic [4:0] a);
        logic [15:0] m;
        m = `SCE_MAX_WORD;
        unique case (a)
            `SCE_A_PV_SRC: m = `SCE_MAX_PV;
            `SCE_A_SP_SRC: m = `SCE_MAX_SP;
            `SCE_A_PRIMARY_OUTPUT_ACT: m = `SCE_MAX_BIT;
            `SCE_A_SECONDARY_OUTPUT_FN: m = `SCE_MAX_SECONDARY_OUTPUT;
            `SCE_A_IN1_UNIT, `SCE_A_IN2_UNIT: m = `SCE_MAX_UNIT;
            `SCE_A_DP1, `SCE_A_DP2: m = `SCE_MAX_DP;
            `SCE_A_AL1_FN, `SCE_A_AL2_FN: m = `SCE_MAX_AL;
            default: m = `SCE_MAX_WORD;
        endcase
        return m;
    endfunction : max_of

    function automatic logic is_diff_alarm(input logic [15:0] f);
        return f >= `SCE_AL_DIFF_MIN;
    endfunction : is_diff_alarm

    // Individual conflict conditions, index = error code
    function automatic logic [7:0] conflicts(input sce_cfg_t c);
        logic [7:0] h;
        logic pv_diff;
        logic sp_in;
        logic mism;
        h = 8'h00;
        pv_diff = c[`SCE_A_PV_SRC] == `SCE_PV_DIFF12 || c[`SCE_A_PV_SRC] == `SCE_PV_DIFF21;
        sp_in = c[`SCE_A_SP_SRC] == `SCE_SP_FIRST || c[`SCE_A_SP_SRC] == `SCE_SP_SECOND;
        mism = c[`SCE_A_IN1_UNIT] != c[`SCE_A_IN2_UNIT] || c[`SCE_A_DP1] != c[`SCE_A_DP2];
        h[1] = c[`SCE_A_PV_SRC] == `SCE_PV_FIRST && c[`SCE_A_SP_SRC] == `SCE_SP_FIRST;
        h[2] = c[`SCE_A_PV_SRC] == `SCE_PV_SECOND && c[`SCE_A_SP_SRC] == `SCE_SP_SECOND;
        h[3] = pv_diff && sp_in;
        h[4] = c[`SCE_A_SECONDARY_OUTPUT_FN] == `SCE_SECONDARY_OUTPUT_COOL
            && (c[`SCE_A_PRIMARY_OUTPUT_ACT] == `SCE_PRIMARY_OUTPUT_DIRECT
            || c[`SCE_A_PB_A] == 16'h0000 || c[`SCE_A_PB_B] == 16'h0000
            || c[`SCE_A_TI_A] == 16'h0000 || c[`SCE_A_TI_B] == 16'h0000);
        h[5] = mism && (pv_diff || sp_in || is_diff_alarm(c[`SCE_A_AL1_FN])
            || is_diff_alarm(c[`SCE_A_AL2_FN]));
        h[6] = c[`SCE_A_SECONDARY_OUTPUT_FN] == `SCE_SECONDARY_OUTPUT_ALARM && c[`SCE_A_AL2_FN] == `SCE_AL_NONE;
        h[7] = c[`SCE_A_AL1_FN] == `SCE_AL_TIMER && c[`SCE_A_AL2_FN] == `SCE_AL_TIMER;
        return h;
    endfunction : conflicts

    // ----------------------------------------
    // State
    // ----------------------------------------
    sce_state_t s_r;
    sce_state_t s_nxt;
    logic [7:0] hit;
    logic [7:0] req_err;
    logic [7:0] setup_code;
    logic req_any;
    logic req_clear;

    assign hit = conflicts(s_r.cfg);
    assign req_any = host_req.wr || host_req.rd;

    // ----------------------------------------
    // Request checking
    // ----------------------------------------
    always_comb
    begin
        req_err = `SCE_E_NONE;
        if (req_any)
        begin
            if ((host_req.rd && host_req.func != `SCE_FN_READ)
                || (host_req.wr && host_req.func != `SCE_FN_WRITE))
                req_err = `SCE_E_FUNC;
            else if (host_req.addr > `SCE_A_LAST)
                req_err = `SCE_E_RANGE;
            else if (host_req.addr == `SCE_A_HOLE)
                req_err = `SCE_E_NOPAR;
            else if (host_req.wr && host_req.addr == `SCE_A_STATUS)
                req_err = `SCE_E_RDONLY;
            else if (host_req.wr && host_req.addr < `SCE_A_HOLE
                && host_req.wdata > max_of(host_req.addr))
                req_err = `SCE_E_VALUE;
        end
    end

    assign req_clear = host_req.wr && req_err == `SCE_E_NONE && host_req.addr == `SCE_A_COMM;

    // Lowest conflict code wins
    always_comb
    begin
        setup_code = `SCE_E_NONE;
        for (int k = 7; k >= 1; k--)
        begin
            if (hit[k])
                setup_code = 8'(k);
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rdata = 16'h0000;
        if (host_req.wr && req_err == `SCE_E_NONE && host_req.addr < `SCE_A_HOLE)
            s_nxt.cfg[host_req.addr[3:0]] = host_req.wdata;
        if (host_req.rd && req_err == `SCE_E_NONE)
        begin
            if (host_req.addr < `SCE_A_HOLE)
                s_nxt.rdata = s_r.cfg[host_req.addr[3:0]];
            else if (host_req.addr == `SCE_A_STATUS)
                s_nxt.rdata = {8'h00, s_r.err_code};
            else
                s_nxt.rdata = {8'h00, s_r.comm_err};
        end
        // New fault wins over a clear in the same cycle
        if (req_err != `SCE_E_NONE)
            s_nxt.comm_err = req_err;
        else if (req_clear)
            s_nxt.comm_err = `SCE_E_NONE;
        if (tune_fail)
            s_nxt.tune_err = 1'b1;
        else if (req_clear)
            s_nxt.tune_err = 1'b0;
        if (setup_code != `SCE_E_NONE)
            s_nxt.err_code = setup_code;
        else if (s_r.comm_err != `SCE_E_NONE)
            s_nxt.err_code = s_r.comm_err;
        else if (s_r.tune_err)
            s_nxt.err_code = `SCE_E_TUNE;
        else
            s_nxt.err_code = `SCE_E_NONE;
        // Code 6 is displayed as eight
        s_nxt.err_shown = (s_nxt.err_code == `SCE_E_AL2) ? `SCE_E_AL2_SHOWN : s_nxt.err_code;
        s_nxt.alarm2 = s_r.cfg[`SCE_A_SECONDARY_OUTPUT_FN] == `SCE_SECONDARY_OUTPUT_ALARM
            && s_r.cfg[`SCE_A_AL2_FN] != `SCE_AL_NONE && alarm2_trip;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign host_rdata = s_r.rdata;
    assign err_code = s_r.err_code;
    assign err_shown = s_r.err_shown;
    assign alarm2_out = s_r.alarm2;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_first_both: assert property (hit[1] |=> err_code == `SCE_E_PV1)
        else $error("first input clash not reported");

    a_second_both: assert property (hit[2] && !hit[1] |=> err_code == `SCE_E_PV2)
        else $error("second input clash not reported");

    a_diff_source: assert property (hit[3] |=> err_code == `SCE_E_DIFF)
        else $error("difference source clash not reported");

    a_cool_conflict: assert property (hit[4] && hit[3:1] == 3'b000
        |=> err_code == `SCE_E_COOL)
        else $error("cooling conflict not reported");

    a_unit_mismatch: assert property (hit[5] && hit[4:1] == 4'h0
        |=> err_code == `SCE_E_UNIT)
        else $error("unit mismatch not reported");

    a_al2_shown: assert property (hit[6] && hit[5:1] == 5'h00
        |=> err_code == `SCE_E_AL2 && err_shown == `SCE_E_AL2_SHOWN)
        else $error("alarm 2 duty conflict not shown as eight");

    a_al2_silent: assert property (s_r.cfg[`SCE_A_AL2_FN] == `SCE_AL_NONE
        |=> !alarm2_out)
        else $error("output 2 alarmed with no alarm 2 function");

    a_timer_twice: assert property (hit[7] && hit[6:1] == 6'h00
        |=> err_code == `SCE_E_TIMER)
        else $error("double dwell timer not reported");

    a_bad_func: assert property (host_req.rd && host_req.func != `SCE_FN_READ
        |=> s_r.comm_err == `SCE_E_FUNC ##1 (hit == 8'h00) |-> err_code == `SCE_E_FUNC)
        else $error("bad function code not reported");

    a_addr_range: assert property (req_any && host_req.addr > `SCE_A_LAST
        && host_req.func inside {`SCE_FN_READ, `SCE_FN_WRITE}
        |=> s_r.comm_err inside {`SCE_E_FUNC, `SCE_E_RANGE})
        else $error("out of range address not reported");

    a_no_param: assert property (host_req.rd && host_req.func == `SCE_FN_READ
        && host_req.addr == `SCE_A_HOLE |=> s_r.comm_err == `SCE_E_NOPAR)
        else $error("missing parameter not reported");

    a_read_only: assert property (host_req.wr && host_req.func == `SCE_FN_WRITE
        && host_req.addr == `SCE_A_STATUS |=> s_r.comm_err == `SCE_E_RDONLY && $stable(s_r.cfg))
        else $error("read-only write not refused");

    a_value_range: assert property (host_req.wr && host_req.func == `SCE_FN_WRITE
        && host_req.addr < `SCE_A_HOLE && host_req.wdata > max_of(host_req.addr)
        |=> s_r.comm_err == `SCE_E_VALUE && $stable(s_r.cfg))
        else $error("out of range value accepted");

    a_tune_fail: assert property (tune_fail && hit == 8'h00 && s_r.comm_err == `SCE_E_NONE
        && !req_any ##1 !req_any |=> err_code == `SCE_E_TUNE)
        else $error("tuning failure not reported");

    a_setup_clears: assert property (hit == 8'h00 && s_r.comm_err == `SCE_E_NONE
        && !s_r.tune_err |=> err_code == `SCE_E_NONE)
        else $error("error code left after conflict cleared");

    a_refused_read: assert property (host_req.rd && req_err != `SCE_E_NONE
        |=> host_rdata == 16'h0000)
        else $error("refused read returned data");

    a_rdata_idle: assert property (!host_req.rd |=> host_rdata == 16'h0000)
        else $error("read data outside its cycle");

    a_shown_match: assert property (err_code != `SCE_E_AL2
        |-> err_shown == err_code)
        else $error("displayed code differs from error code");

    a_comm_latch: assert property (req_err != `SCE_E_NONE
        |=> s_r.comm_err == $past(req_err))
        else $error("request fault not latched");

    a_tune_latch: assert property (tune_fail |=> s_r.tune_err)
        else $error("tuning failure not latched");

    a_refused_store: assert property (req_err != `SCE_E_NONE
        |=> $stable(s_r.cfg))
        else $error("refused request changed a setting");

    a_one_code: assert property (setup_code != `SCE_E_NONE
        |=> err_code == $past(setup_code))
        else $error("setup code priority broken");

    a_cfg_write: assert property (host_req.wr && req_err == `SCE_E_NONE
        && host_req.addr < `SCE_A_HOLE |=> s_r.cfg[$past(host_req.addr[3:0])] == $past(host_req.wdata))
        else $error("valid write not stored");

    a_alarm_drive: assert property (s_r.cfg[`SCE_A_SECONDARY_OUTPUT_FN] == `SCE_SECONDARY_OUTPUT_ALARM
        && s_r.cfg[`SCE_A_AL2_FN] != `SCE_AL_NONE && alarm2_trip |=> alarm2_out)
        else $error("output 2 alarm not driven");

    a_comm_clear: assert property (req_clear && !tune_fail
        |=> s_r.comm_err == `SCE_E_NONE && !s_r.tune_err)
        else $error("fault clear ignored");

    a_status_read: assert property (host_req.rd && req_err == `SCE_E_NONE
        && host_req.addr == `SCE_A_STATUS |=> host_rdata == {8'h00, $past(err_code)})
        else $error("status read returned wrong code");

endmodule : sce_checker

`default_nettype wire

// ==== sim/sce_host.sv ====
`timescale 1ns/1ps
`default_nettype none

module sce_host
    import sce_pkg::*;
(
    input wire logic mclk,
    output sce_req_t req,
    input wire logic [15:0] rdata
);
    initial req = '0;

    // One request, held across its take edge, read data caught mid-cycle
    task automatic xfer(input logic wr, input logic [7:0] func, input logic [4:0] addr,
        input logic [15:0] data, output logic [15:0] rd);
        @(posedge mclk);
        req <= '{wr: wr, rd: !wr, func: func, addr: addr, wdata: data};
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b0, func: ~func, addr: ~addr, wdata: ~data};
        @(negedge mclk);
        rd = rdata;
    endtask : xfer
endmodule : sce_host

`default_nettype wire

// ==== sim/tb_setup_conflict_error_checker.sv ====
`include "sce_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_setup_conflict_error_checker
    import sce_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic tune_fail = 1'b0;
    logic alarm2_trip = 1'b0;
    sce_req_t host_req;
    logic [15:0] host_rdata;
    logic [7:0] err_code;
    logic [7:0] err_shown;
    logic alarm2_out;
    logic [15:0] cfg [14];
    logic [7:0] comm;
    logic tune;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [23:0] seq [19] = '{24'h01_0001, 24'h00_0001, 24'h01_0002, 24'h00_0002,
        24'h00_0000, 24'h01_0000, 24'h03_0001, 24'h04_0005, 24'h05_0005, 24'h06_0005,
        24'h07_0005, 24'h02_0001, 24'h02_0000, 24'h08_0001, 24'h0C_0004, 24'h0C_0000,
        24'h03_0002, 24'h0D_0001, 24'h0C_0001};

    always #5 mclk = ~mclk;

    sce_host u_sce_host (.mclk(mclk), .req(host_req), .rdata(host_rdata));

    sce_checker u_sce_checker (.mclk(mclk), .rst_n(rst_n), .host_req(host_req),
        .tune_fail(tune_fail), .alarm2_trip(alarm2_trip), .host_rdata(host_rdata),
        .err_code(err_code), .err_shown(err_shown), .alarm2_out(alarm2_out));

    // ----------------------------------------
    // Expectation functions
    // ----------------------------------------
    function automatic logic [15:0] maxv(input logic [4:0] a);
        case (a)
            5'h00, 5'h0A, 5'h0B: return 16'h0003;
            5'h01, 5'h03, 5'h08, 5'h09: return 16'h0002;
            5'h02: return 16'h0001;
            5'h0C, 5'h0D: return 16'h0007;
            default: return 16'h270F;
        endcase
    endfunction : maxv

    function automatic logic [7:0] setup_code();
        logic in_sp;
        logic mix;
        in_sp = cfg[1] == 16'h0001 || cfg[1] == 16'h0002;
        mix = cfg[0] >= 16'h0002 || in_sp || cfg[12] >= 16'h0004 || cfg[13] >= 16'h0004;
        if (cfg[0] == 16'h0000 && cfg[1] == 16'h0001) return 8'h01;
        if (cfg[0] == 16'h0001 && cfg[1] == 16'h0002) return 8'h02;
        if (cfg[0] >= 16'h0002 && in_sp) return 8'h03;
        if (cfg[3] == 16'h0001 && (cfg[2] == 16'h0001 || cfg[4] == 0 || cfg[5] == 0
            || cfg[6] == 0 || cfg[7] == 0)) return 8'h04;
        if ((cfg[8] != cfg[9] || cfg[10] != cfg[11]) && mix) return 8'h05;
        if (cfg[3] == 16'h0002 && cfg[13] == 16'h0000) return 8'h06;
        if (cfg[12] == 16'h0001 && cfg[13] == 16'h0001) return 8'h07;
        return 8'h00;
    endfunction : setup_code

    function automatic logic [7:0] exp_err();
        if (setup_code() != 0) return setup_code();
        if (comm != 0) return comm;
        return tune ? 8'h1A : 8'h00;
    endfunction : exp_err

    function automatic logic [7:0] fault(input logic wr, input logic [7:0] f,
        input logic [4:0] a, input logic [15:0] d);
        if (f != (wr ? 8'h06 : 8'h03)) return 8'h0A;
        if (a > 5'h10) return 8'h0B;
        if (a == 5'h0E) return 8'h0C;
        if (wr && a == 5'h0F) return 8'h0E;
        if (wr && a < 5'h0E && d > maxv(a)) return 8'h0F;
        return 8'h00;
    endfunction : fault

    // ----------------------------------------
    // Checks and bus tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic clr_model();
        foreach (cfg[i]) cfg[i] = 16'h0000;
        comm = 8'h00;
        tune = 1'b0;
    endtask : clr_model

    task automatic access(input logic wr, input logic [7:0] f, input logic [4:0] a,
        input logic [15:0] d);
        logic [7:0] e;
        logic [15:0] got;
        logic [15:0] want;
        e = fault(wr, f, a, d);
        want = 16'h0000;
        if (e == 0 && a < 5'h0E) want = cfg[a];
        if (e == 0 && a == 5'h0F) want = {8'h00, exp_err()};
        if (e == 0 && a == 5'h10) want = {8'h00, comm};
        u_sce_host.xfer(wr, f, a, d, got);
        if (!wr) chk(got, want);
        if (e != 0) comm = e;
        else if (wr && a < 5'h0E) cfg[a] = d;
        else if (wr && a == 5'h10) clr_model_comm();
        repeat (2) @(posedge mclk);
        #1;
        chk({8'h00, err_code}, {8'h00, exp_err()});
        chk({8'h00, err_shown}, {8'h00, exp_err() == 8'h06 ? 8'h08 : exp_err()});
    endtask : access

    task automatic clr_model_comm();
        comm = 8'h00;
        tune = 1'b0;
    endtask : clr_model_comm

    task automatic alarm(input logic t);
        @(posedge mclk);
        alarm2_trip <= t;
        repeat (2) @(posedge mclk);
        #1;
        chk({15'h0000, alarm2_out}, {15'h0000, t && cfg[3] == 16'h0002 && cfg[13] != 0});
    endtask : alarm

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [4:0] a;
        int k;
        clr_model();
        k = $urandom(38);
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        chk({8'h00, err_code}, 16'h0000);
        foreach (seq[i]) access(1'b1, 8'h06, seq[i][20:16], seq[i][15:0]);
        access(1'b1, 8'h06, 5'h0C, 16'h0000);
        alarm(1'b1);
        access(1'b1, 8'h06, 5'h0D, 16'h0000);
        alarm(1'b1);
        access(1'b1, 8'h03, 5'h00, 16'h0000);
        access(1'b0, 8'h07, 5'h00, 16'h0000);
        access(1'b0, 8'h03, 5'h11, 16'h0000);
        access(1'b0, 8'h03, 5'h0E, 16'h0000);
        access(1'b1, 8'h06, 5'h0F, 16'h0005);
        access(1'b1, 8'h06, 5'h0D, 16'h0008);
        access(1'b0, 8'h03, 5'h0D, 16'h0000);
        access(1'b0, 8'h03, 5'h10, 16'h0000);
        access(1'b1, 8'h06, 5'h10, 16'h0000);
        access(1'b1, 8'h06, 5'h03, 16'h0000);
        @(posedge mclk);
        tune_fail <= 1'b1;
        @(posedge mclk);
        tune_fail <= 1'b0;
        tune = 1'b1;
        access(1'b0, 8'h03, 5'h0F, 16'h0000);
        access(1'b1, 8'h06, 5'h10, 16'h0001);
        repeat (300)
        begin
            a = 5'($urandom_range(13));
            case ($urandom_range(4))
                0: access(1'b0, 8'h03, 5'($urandom_range(16)), 16'h0000);
                1: alarm(1'($urandom_range(1)));
                2: access(1'b1, 8'h06, 5'h10, 16'($urandom));
                default: access(1'b1, 8'h06, a, 16'($urandom_range(maxv(a) + 1)));
            endcase
        end
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        clr_model();
        access(1'b0, 8'h03, 5'h03, 16'h0000);
        stop_test();
    end

    initial
    begin
        #500000;
        n_mismatch++;
        stop_test();
    end
endmodule : tb_setup_conflict_error_checker

`default_nettype wire
